// [inc/sdf_pkg.sv]
/*
  Shared constants and types of the segment display frame control block:
  register indices, bit positions, reset values, pin masks and frame timing.
  Assumes a Wishbone slave with 32-bit data and byte address = 4 * index.
*/
package sdf_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL_A   = 10'h0e4;
  localparam logic [9:0] IDX_CTRL_B   = 10'h0e5;
  localparam logic [9:0] IDX_CONTRAST = 10'h0e7;
  localparam logic [9:0] IDX_SEG_BASE = 10'h0f0;
  localparam int         ADR_W        = 12;
  localparam int         SEG_DEPTH    = 16;
  localparam int         SEG_AW       = 4;
  localparam int         NUM_COM      = 4;
  localparam int         NUM_SEG      = 25;
  // control/status a bit positions
  localparam int A_EN   = 7;
  localparam int A_LP   = 6;
  localparam int A_FLAG = 4;
  localparam int A_IE   = 3;
  localparam int A_BD   = 2;
  localparam int A_CCD  = 1;
  localparam int A_BL   = 0;
  // control/status b bit positions
  localparam int B_CS     = 7;
  localparam int B_HB     = 6;
  localparam int B_DUTY_H = 5;
  localparam int B_DUTY_L = 4;
  localparam int B_PM_H   = 2;
  localparam int B_PM_L   = 0;
  // reset values
  localparam logic [7:0] CTRL_A_RST   = 8'h00;
  localparam logic [7:0] CTRL_B_RST   = 8'h00;
  localparam logic [7:0] CONTRAST_RST = 8'h00;
  // frame length in clock cycles (prescaler and divider are outside)
  localparam int FRAME_CYCLES_DEF = 4000;
  // commons in use per duty code
  localparam logic [3:0] COM_MASK [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
  // segment pins driven per pin mask code
  localparam logic [24:0] SEG_MASK [8] = '{25'h0001fff, 25'h0007fff,
    25'h001ffff, 25'h007ffff, 25'h01fffff, 25'h07fffff, 25'h0ffffff,
    25'h1ffffff};
  // bus slave states
  typedef enum {BUS_IDLE, BUS_WAIT, BUS_ACK} sdf_bus_type;
endpackage : sdf_pkg

// [hw/sdf_frame_timer.sv]
/*
  Frame timer: emits a one-cycle frame start strobe and a frame phase bit.
  Assumes the async tick is a synchronous one-cycle enable pulse.
*/
`timescale 1ns/1ns
module sdf_frame_timer #(
  parameter int CYCLES = 4000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  input  wire logic use_async,
  input  wire logic async_tick,
  // frame events
  output logic      frame_stb,
  output logic      phase
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic          started_q;
  logic          adv;

  // the async source only advances the count on its own ticks
  assign adv = use_async ? async_tick : 1'b1;

  // count frames; stopping clears everything so a restart begins a frame
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_q     <= '0;
      started_q <= 1'b0;
      frame_stb <= 1'b0;
      phase     <= 1'b0;
    end else begin
      frame_stb <= 1'b0;
      if (!started_q) begin
        started_q <= 1'b1;
        frame_stb <= 1'b1;
      end else if (adv) begin
        if (cnt_q == LAST) begin
          cnt_q     <= '0;
          frame_stb <= 1'b1;
          phase     <= ~phase;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule : sdf_frame_timer

// [hw/sdf_seg_mem.sv]
/*
  Segment memory: software copy with registered read, plus a working copy
  loaded on the latch strobe. Assumes one write per cycle.
*/
`timescale 1ns/1ns
module sdf_seg_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // software port
  input  wire logic               wr_en,
  input  wire logic [AW-1:0]      wr_addr,
  input  wire logic [7:0]         wr_data,
  input  wire logic [AW-1:0]      rd_addr,
  output logic      [7:0]         rd_data,
  // frame latch
  input  wire logic               latch_stb,
  output logic      [DEPTH*8-1:0] work
);
  logic [7:0] mem_q [DEPTH];

  // registered read keeps the bus read path short
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

  // one entry each: software copy and working copy
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        mem_q[i]        <= 8'h00;
        work[i*8 +: 8]  <= 8'h00;
      end else begin
        if (wr_en && wr_addr == AW'(i)) begin
          mem_q[i] <= wr_data;
        end
        if (latch_stb) begin
          work[i*8 +: 8] <= mem_q[i];
        end
      end
    end
  end
endmodule : sdf_seg_mem

// [hw/sdf_frame_control.sv]
/*
  Segment display frame control: Wishbone register file, frame latching,
  frame start flag and interrupt request, pin function selection.
  Assumes a classic Wishbone master and that the analog drive, prescaler
  and pin muxes outside follow the enables driven here.
*/
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
// Notes on behaviour
// - latch memory, blank, waveform, contrast at frame
// - software writes accepted at any time
// - enable starts; clearing stops at once
// - disabled means all pins are ports
// - waveform bit applies from next frame
// - bit five reads zero, ignores writes
// - flag sets with the data latch
// - request only when flag, enable, global set
// - flag cleared by vector or written one
// - writing back a set flag clears it
// - low power: flag every second frame
// - buffer disable bit turns buffers off
// - supply disable bit turns generator off
// - blank after frame, ground pins, keep memory
// - clock select chooses system or async
// - bias bit selects third or half
// - duty field selects commons in use
// - pin mask sets driven segment count
module sdf_frame_control
  import sdf_pkg::*;
#(
  parameter int FRAME_CYCLES = sdf_pkg::FRAME_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESET_N,
  // wishbone slave
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [sdf_pkg::ADR_W-1:0]   WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [31:0]                 WB_DAT_I,
  output logic      [31:0]                 WB_DAT_O,
  output logic                             WB_ACK_O,
  // processor side
  input  wire logic                        IRQ_GLOBAL_EN,
  input  wire logic                        IRQ_VECTOR_TAKEN,
  input  wire logic                        ASYNC_TICK,
  output logic                             FRAME_IRQ,
  // display drive control
  output logic                             DRIVE_ON,
  output logic      [sdf_pkg::NUM_COM-1:0] COM_ACTIVE,
  output logic      [sdf_pkg::NUM_SEG-1:0] SEG_ACTIVE,
  output logic                             PIN_GROUND,
  output logic                             LOW_POWER_WAVE,
  output logic                             HALF_BIAS,
  output logic                             LEVEL_BUF_OFF,
  output logic                             INT_SUPPLY_OFF,
  output logic                             CLK_ASYNC_SEL,
  output logic      [7:0]                  CONTRAST,
  output logic      [sdf_pkg::SEG_DEPTH*8-1:0] SEG_DATA
);
  sdf_bus_type     state_q;
  logic [9:0]      idx_q;
  logic            we_q;
  logic            sel_q;
  logic [7:0]      wdat_q;
  logic            wr_go;
  logic            seg_hit_q;
  logic [7:0]      mem_rd;
  logic            frame_stb;
  logic            phase;
  logic            latch_stb;
  logic            flag_clr;
  logic [7:0]      rd_mux;
  // control a
  logic            en_q;
  logic            lp_q;
  logic            flag_q;
  logic            ie_q;
  logic            bd_q;
  logic            ccd_q;
  logic            bl_q;
  // control b
  logic            cs_q;
  logic            hb_q;
  logic [1:0]      duty_q;
  logic [2:0]      pm_q;
  logic [7:0]      contrast_q;
  // working copies
  logic            lp_work_q;
  logic            bl_work_q;

  // bus handshake: take at idle, act in wait, answer in ack
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_q   <= BUS_IDLE;
      idx_q     <= 10'h000;
      we_q      <= 1'b0;
      sel_q     <= 1'b0;
      wdat_q    <= 8'h00;
      seg_hit_q <= 1'b0;
      WB_ACK_O  <= 1'b0;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          WB_ACK_O <= 1'b0;
          if (WB_CYC_I && WB_STB_I) begin
            state_q   <= BUS_WAIT;
            idx_q     <= WB_ADR_I[ADR_W-1:2];
            we_q      <= WB_WE_I;
            sel_q     <= WB_SEL_I[0];
            wdat_q    <= WB_DAT_I[7:0];
            seg_hit_q <= WB_ADR_I[ADR_W-1:2+SEG_AW] == IDX_SEG_BASE[9:SEG_AW];
          end
        end
        BUS_WAIT: begin
          state_q  <= BUS_ACK;
          WB_ACK_O <= 1'b1;
        end
        BUS_ACK: begin
          state_q  <= BUS_IDLE;
          WB_ACK_O <= 1'b0;
        end
        default: begin
          state_q  <= BUS_IDLE;
          WB_ACK_O <= 1'b0;
        end
      endcase
    end
  end

  // writes land in the wait cycle, whatever the frame is doing
  assign wr_go = (state_q == BUS_WAIT) && we_q && sel_q;

  // read mux; unmapped indices read zero
  always_comb begin
    rd_mux = 8'h00;
    if (seg_hit_q) begin
      rd_mux = mem_rd;
    end else if (idx_q == IDX_CTRL_A) begin
      rd_mux = {en_q, lp_q, 1'b0, flag_q, ie_q, bd_q, ccd_q, bl_q};
    end else if (idx_q == IDX_CTRL_B) begin
      rd_mux = {cs_q, hb_q, duty_q, 1'b0, pm_q};
    end else if (idx_q == IDX_CONTRAST) begin
      rd_mux = contrast_q;
    end
  end

  // read data register; upper lanes always zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      WB_DAT_O <= 32'h00000000;
    end else if (state_q == BUS_WAIT) begin
      WB_DAT_O <= {24'h000000, rd_mux};
    end
  end

  // control a; bit five has no storage and bit four is write-one-to-clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      {en_q, lp_q, ie_q, bd_q, ccd_q, bl_q} <= {CTRL_A_RST[A_EN],
        CTRL_A_RST[A_LP], CTRL_A_RST[A_IE], CTRL_A_RST[A_BD],
        CTRL_A_RST[A_CCD], CTRL_A_RST[A_BL]};
    end else if (wr_go && idx_q == IDX_CTRL_A) begin
      en_q  <= wdat_q[A_EN];
      lp_q  <= wdat_q[A_LP];
      ie_q  <= wdat_q[A_IE];
      bd_q  <= wdat_q[A_BD];
      ccd_q <= wdat_q[A_CCD];
      bl_q  <= wdat_q[A_BL];
    end
  end

  // control b and contrast
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      cs_q       <= CTRL_B_RST[B_CS];
      hb_q       <= CTRL_B_RST[B_HB];
      duty_q     <= CTRL_B_RST[B_DUTY_H:B_DUTY_L];
      pm_q       <= CTRL_B_RST[B_PM_H:B_PM_L];
      contrast_q <= CONTRAST_RST;
    end else if (wr_go) begin
      if (idx_q == IDX_CTRL_B) begin
        cs_q   <= wdat_q[B_CS];
        hb_q   <= wdat_q[B_HB];
        duty_q <= wdat_q[B_DUTY_H:B_DUTY_L];
        pm_q   <= wdat_q[B_PM_H:B_PM_L];
      end
      if (idx_q == IDX_CONTRAST) begin
        contrast_q <= wdat_q;
      end
    end
  end

  // frame timing on system clock or async ticks
  sdf_frame_timer #(
    .CYCLES     (FRAME_CYCLES)
  ) u_timer (
    .clk        (CORE_CLK),
    .rst_n      (RESET_N),
    .run        (en_q),
    .use_async  (cs_q),
    .async_tick (ASYNC_TICK),
    .frame_stb  (frame_stb),
    .phase      (phase)
  );

  // low power needs two equal frames, so only every second one latches
  assign latch_stb = frame_stb && (!lp_work_q || !phase);

  // working copies; the running frame takes waveform, blank and contrast only from them
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      lp_work_q <= 1'b0;
      bl_work_q <= 1'b0;
      CONTRAST  <= CONTRAST_RST;
    end else if (latch_stb) begin
      lp_work_q <= lp_q;
      bl_work_q <= bl_q;
      CONTRAST  <= contrast_q;
    end
  end

  // segment memory and its frame copy
  sdf_seg_mem #(
    .DEPTH     (SEG_DEPTH),
    .AW        (SEG_AW)
  ) u_mem (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .wr_en     (wr_go && seg_hit_q),
    .wr_addr   (idx_q[SEG_AW-1:0]),
    .wr_data   (wdat_q),
    .rd_addr   (WB_ADR_I[SEG_AW+1:2]),
    .rd_data   (mem_rd),
    .latch_stb (latch_stb),
    .work      (SEG_DATA)
  );

  // a read-modify-write that returns a set flag clears it too
  assign flag_clr = IRQ_VECTOR_TAKEN ||
    (wr_go && idx_q == IDX_CTRL_A && wdat_q[A_FLAG]);

  // frame start flag; a frame arriving with a clear wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      flag_q <= CTRL_A_RST[A_FLAG];
    end else if (latch_stb) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // interrupt request, level while all three agree
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      FRAME_IRQ <= 1'b0;
    end else begin
      FRAME_IRQ <= flag_q && ie_q && IRQ_GLOBAL_EN;
    end
  end

  // pin function and analog controls; disable takes effect next edge
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      DRIVE_ON       <= 1'b0;
      COM_ACTIVE     <= '0;
      SEG_ACTIVE     <= '0;
      PIN_GROUND     <= 1'b0;
      LOW_POWER_WAVE <= 1'b0;
      HALF_BIAS      <= 1'b0;
      LEVEL_BUF_OFF  <= 1'b0;
      INT_SUPPLY_OFF <= 1'b0;
      CLK_ASYNC_SEL  <= 1'b0;
    end else begin
      DRIVE_ON       <= en_q;
      COM_ACTIVE     <= en_q ? COM_MASK[duty_q] : '0;
      SEG_ACTIVE     <= en_q ? SEG_MASK[pm_q] : '0;
      PIN_GROUND     <= en_q && bl_work_q;
      LOW_POWER_WAVE <= lp_work_q;
      HALF_BIAS      <= hb_q;
      LEVEL_BUF_OFF  <= bd_q;
      INT_SUPPLY_OFF <= ccd_q;
      CLK_ASYNC_SEL  <= cs_q;
    end
  end

  // bus, flag and pin properties; none is checked while reset is low
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_req;
    state_q == BUS_IDLE && WB_CYC_I && WB_STB_I;
  endsequence
  sequence s_flag_w1;
    wr_go && idx_q == IDX_CTRL_A && wdat_q[A_FLAG] && !latch_stb;
  endsequence
  sequence s_rd_ctrl_a;
    state_q == BUS_ACK && idx_q == IDX_CTRL_A;
  endsequence

  a_ack_timing: assert property (s_req |=> !WB_ACK_O ##1 WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not two cycles after request");
  a_flag_on_frame: assert property (latch_stb |=> flag_q)
    else $error("flag not set at frame latch");
  a_flag_w1c: assert property (s_flag_w1 |=> !flag_q)
    else $error("written one did not clear flag");
  a_irq_gating: assert property (FRAME_IRQ |-> $past(flag_q && ie_q && IRQ_GLOBAL_EN))
    else $error("irq without flag, enable and global enable");
  a_res_bit_zero: assert property (s_rd_ctrl_a |-> !WB_DAT_O[5])
    else $error("reserved bit reads one");
  a_stop_at_once: assert property ($fell(en_q) |=> COM_ACTIVE == '0 && SEG_ACTIVE == '0)
    else $error("pins still driven after disable");
  a_lp_skip: assert property (frame_stb && lp_work_q && phase && !flag_q |=> !flag_q)
    else $error("flag set on skipped low power frame");
  a_work_hold: assert property (!latch_stb |=> $stable(lp_work_q) && $stable(bl_work_q))
    else $error("working copy changed between frames");
  a_blank_pins: assert property (en_q && bl_work_q |=> PIN_GROUND)
    else $error("blank not grounding pins");
  a_vec_clear: assert property (IRQ_VECTOR_TAKEN && !latch_stb |=> !flag_q)
    else $error("vector taken did not clear flag");
  a_frame_flag: assert property (frame_stb && !lp_work_q |=> flag_q)
    else $error("default waveform frame did not set flag");
  a_drive_off: assert property (!en_q |=> !DRIVE_ON && !PIN_GROUND)
    else $error("drive still on after disable");
endmodule : sdf_frame_control

// [tb/sdf_glass_model.sv]
/*
  Passive glass model: a load on the common pins only (it has no segment input) that counts
  the cycles in which it is discharged through grounded pins.
  Assumes the drive controls come straight from the frame control block.
*/
`timescale 1ns/1ns
module sdf_glass_model (
  // clock
  input  wire logic        clk,
  // drive controls
  input  wire logic        drive_on,
  input  wire logic        pin_ground,
  input  wire logic [3:0]  com_active,
  // glass state
  output logic      [15:0] ground_cnt
);
  // the glass never drives back, so discharge time is all it can show
  initial ground_cnt = 16'h0000;
  always @(posedge clk)
    if (drive_on && pin_ground && com_active != 4'h0)
      ground_cnt <= ground_cnt + 16'h0001;
endmodule : sdf_glass_model

// [tb/tb_segment_display_frame_control.sv]
/*
  Self-checking bench of the segment display frame control block.
  Assumes a classic Wishbone master and a frame of FC clocks.
*/
`timescale 1ns/1ns
module tb_segment_display_frame_control;
  import sdf_pkg::*;
  localparam int FC = 64;
  logic         clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic         gie = 1'b0, vec = 1'b0, tick = 1'b0;
  logic [11:0]  adr = 12'h000;
  logic [3:0]   sel = 4'h0;
  logic [3:0]   bsel = 4'hf;
  logic [31:0]  dati = 32'h0, dato;
  logic         ack, irq, on, gnd, lpw, hb, lbo, iso, cks;
  logic [3:0]   com;
  logic [24:0]  seg;
  logic [7:0]   con, a, d;
  logic [127:0] sd;
  logic [15:0]  gcnt;
  logic [31:0]  exp_q[$], msk_q[$];
  int           err_total = 0, checked = 0, cyc_n = 0, n;
  int           npin[8] = '{13, 15, 17, 19, 21, 23, 24, 25};
  integer       seed = 32'h236a4280;

  always #25 clk = ~clk;

  sdf_frame_control #(.FRAME_CYCLES(FC)) DUT (
    .CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .IRQ_GLOBAL_EN(gie),
    .IRQ_VECTOR_TAKEN(vec), .ASYNC_TICK(tick), .FRAME_IRQ(irq),
    .DRIVE_ON(on), .COM_ACTIVE(com), .SEG_ACTIVE(seg), .PIN_GROUND(gnd),
    .LOW_POWER_WAVE(lpw), .HALF_BIAS(hb), .LEVEL_BUF_OFF(lbo),
    .INT_SUPPLY_OFF(iso), .CLK_ASYNC_SEL(cks), .CONTRAST(con),
    .SEG_DATA(sd));

  sdf_glass_model glass (.clk(clk), .drive_on(on), .pin_ground(gnd),
    .com_active(com), .ground_cnt(gcnt));

  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", what, expv, seen);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high
  task automatic bus(logic w, logic [9:0] idx, logic [7:0] v);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= bsel;
    dati <= {24'h0, v};
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  // the note goes on the queue before the request, the monitor compares
  task automatic rd(logic [9:0] idx, logic [31:0] expv, logic [31:0] msk);
    exp_q.push_back(expv);
    msk_q.push_back(msk);
    bus(1'b0, idx, 8'h00);
  endtask : rd

  task automatic clks(int k);
    repeat (k) @(posedge clk);
  endtask : clks

  // wait for a frame request, take the vector, and see the request drop
  task automatic wframe(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (irq !== 1'b1);
    vec <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    clks(2);
    check("irq clear", irq, 1'b0);
  endtask : wframe

  // read monitor: oldest note against the data seen with ack
  always @(posedge clk)
    if (ack === 1'b1 && !we && exp_q.size() > 0)
      check("read", dato & msk_q.pop_front(), exp_q.pop_front());

  // random tick pulses; only counted once the async source is picked
  always @(posedge clk) tick <= $random(seed);

  // hang guard, well above the longest run of the sequence below
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_CTRL_A, 32'h0, 32'hffffffff);
    rd(IDX_CTRL_B, 32'h0, 32'hffffffff);
    rd(10'h000, 32'h0, 32'hffffffff);
    bus(1'b1, IDX_CTRL_A, 8'h02);
    bus(1'b1, IDX_CTRL_A, 8'ha6);
    rd(IDX_CTRL_A, 32'h86, 32'hef);
    check("on", on, 1'b1);
    check("buf off", lbo, 1'b1);
    check("supply off", iso, 1'b1);
    // every duty and pin mask code; bit 3 written but must read 0
    for (int i = 0; i < 8; i++) begin
      d = {1'b0, i[0], i[1:0], 1'b1, i[2:0]};
      bus(1'b1, IDX_CTRL_B, d);
      rd(IDX_CTRL_B, {24'h0, d & 8'hf7}, 32'hff);
      check("com", com, (32'h2 << i[1:0]) - 32'h1);
      check("seg", seg, (32'h1 << npin[i]) - 32'h1);
      check("bias", hb, i[0]);
    end
    // a write without the low byte lane is acked and dropped
    bsel = 4'he;
    bus(1'b1, IDX_CTRL_B, 8'h00);
    bsel = 4'hf;
    rd(IDX_CTRL_B, 32'h77, 32'hff);
    bus(1'b1, IDX_CTRL_A, 8'h88);
    gie <= 1'b1;
    do @(posedge clk); while (irq !== 1'b1);
    rd(IDX_CTRL_A, 32'h98, 32'hff);
    gie <= 1'b0;
    clks(2);
    check("irq gated", irq, 1'b0);
    gie <= 1'b1;
    bus(1'b1, IDX_CTRL_A, 8'h88);
    check("irq kept", irq, 1'b1);
    bus(1'b1, IDX_CTRL_A, 8'h98);
    rd(IDX_CTRL_A, 32'h88, 32'hff);
    check("irq rmw", irq, 1'b0);
    // mid-frame writes must wait for the next frame boundary
    wframe(n);
    a = $random(seed);
    d = $random(seed) | 8'h01;
    bus(1'b1, IDX_SEG_BASE + 10'h5, d);
    bus(1'b1, IDX_CONTRAST, a | 8'h01);
    check("seg early", sd[47:40], 8'h00);
    check("con early", con, 8'h00);
    wframe(n);
    // three edges of vector hand-off and two four-edge writes fill the rest
    check("gap", n + 11, FC);
    check("seg latch", sd[47:40], d);
    check("con latch", con, a | 8'h01);
    rd(IDX_SEG_BASE + 10'h5, {24'h0, d}, 32'hff);
    bus(1'b1, IDX_CTRL_A, 8'hc8);
    check("lp early", lpw, 1'b0);
    wframe(n);
    check("lp on", lpw, 1'b1);
    wframe(n);
    check("lp gap", n > FC + 8, 1'b1);
    bus(1'b1, IDX_CTRL_A, 8'h88);
    wframe(n);
    wframe(n);
    check("lp off", lpw, 1'b0);
    // blank with flag clear in one write, then stop
    bus(1'b1, IDX_CTRL_A, 8'h99);
    check("gnd early", gnd, 1'b0);
    wframe(n);
    check("gnd", gnd, 1'b1);
    clks(4);
    check("glass", gcnt != 16'h0, 1'b1);
    rd(IDX_SEG_BASE + 10'h5, {24'h0, d}, 32'hff);
    bus(1'b1, IDX_CTRL_A, 8'h00);
    clks(1);
    check("off", {on, gnd, com, seg}, 32'h0);
    clks(3 * FC);
    rd(IDX_CTRL_A, 32'h0, 32'hff);
    // re-initialise while stopped, then run from the async source
    bus(1'b1, IDX_CTRL_B, 8'hb7);
    bus(1'b1, IDX_CTRL_A, 8'h88);
    wframe(n);
    wframe(n);
    check("async sel", cks, 1'b1);
    check("async gap", n > FC + 8, 1'b1);
    summarize();
  end
endmodule : tb_segment_display_frame_control
